//--- rtl/usb_irq_status.sv
// usb function interrupt status flags with apb register access.
// assumes event inputs are synchronous one-cycle pulses from the
// protocol engine running on clock_i.
//
// Overview of operation
// RULE1 - dma terminal count on endpoints 1-4,7,8 sets dma end flag bit 3
// RULE2 - dma end drops that endpoint's dma request until firmware re-enables it
// RULE3 - reading the dma status register leaves dma end flag set
// RULE4 - auto set_configuration/set_feature status stage sets flag bit 2
// RULE5 - firmware must read set target register or later set events stay silent
// RULE6 - reading set target register leaves the set request flag set
// RULE7 - set_feature endpoint also sets the endpoint stall flag
// RULE8 - auto clear_feature status stage sets clear feature flag bit 1
// RULE9 - reading clear target register leaves clear feature flag set
// RULE10 - any endpoint stall, firmware caused too, sets stall flag bit 0
// RULE11 - stall flag survives clear_feature, set_interface, set_configuration, setup
// RULE12 - endpoint status two bit 0 reads zero between masking request and next setup
// RULE13 - any change of status register one raises interrupt line zero
// RULE14 - writing zero to a clear register one bit clears that status bit
// RULE15 - status stage and success flags clear on the next setup token
// RULE16 - all status zero and one sources are ored onto one interrupt
// RULE17 - firmware rechecks status and clears remaining bits one by one
// RULE18 - status one is read-only, byte wide, resets to 00h, bit 7 zero
// RULE19 - ep0 in token answered with nak sets flag bit 6
// RULE20 - ep0 data goes out on the in token after nak control is set
// RULE21 - host receipt of ep0 data, null packet too, sets flag bit 5
// RULE22 - first write to ep0 write buffer clears transmit done flag
`timescale 1ns/1ps

module usb_irq_status
	import usb_irq_pkg::*;
#(
	parameter logic [8:0] DMA_EPS = DMA_EP_MASK
) (
	input  wire logic                        clock_i,
	input  wire logic                        rst_i,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [usb_irq_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [usb_irq_pkg::DATA_W-1:0] pwdata_i,
	input  wire logic [3:0]                  pstrb_i,
	output logic      [usb_irq_pkg::DATA_W-1:0] prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o,
	input  wire usb_irq_pkg::usb_events_t    events_i,
	output usb_irq_pkg::usb_controls_t       controls_o,
	output logic                             usb_irq_line_zero_o
);
	import usb_irq_pkg::*;

	localparam logic [9:0] A_S0  = IDX_STATUS_ZERO[9:0];
	localparam logic [9:0] A_S1  = IDX_STATUS_ONE[9:0];
	localparam logic [9:0] A_C0  = IDX_CLEAR_ZERO[9:0];
	localparam logic [9:0] A_C1  = IDX_CLEAR_ONE[9:0];
	localparam logic [9:0] A_DEN = IDX_DMA_ENABLE[9:0];
	localparam logic [9:0] A_DST = IDX_DMA_STATUS[9:0];
	localparam logic [9:0] A_EP2 = IDX_EP_STATUS_TWO[9:0];
	localparam logic [9:0] A_SET = IDX_SET_TARGET[9:0];

	logic [7:0]  status_zero_q;
	logic [7:0]  status_zero_d;
	logic [7:0]  status_one_q;
	logic [7:0]  status_one_d;
	logic [8:0]  dma_enable_q;
	logic [8:0]  dma_req_q;
	logic [8:0]  dma_done_q;
	logic        set_target_pending_q;
	logic        ep0_mask_q;
	logic        nak_armed_q;
	logic        tx_send_q;
	logic        wbuf_written_q;
	logic        irq_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	logic [9:0]  word_addr;
	logic        setup_phase;
	logic        access_done;
	logic        wr_c0;
	logic        wr_c1;
	logic        wr_den;
	logic        rd_set;
	logic        mapped;
	logic        read_only;
	logic [7:0]  set_zero;
	logic [7:0]  set_one;
	logic [7:0]  keep_zero;
	logic [7:0]  keep_one;
	logic [8:0]  dma_tc_valid;

	assign word_addr   = paddr_i[11:2];
	assign setup_phase = psel_i & ~penable_i;
	assign access_done = psel_i & penable_i & pready_q;

	// byte lane 0 carries the 8-bit registers
	assign wr_c0  = access_done & pwrite_i & pstrb_i[0] & (word_addr == A_C0) & ~pslverr_q;
	assign wr_c1  = access_done & pwrite_i & pstrb_i[0] & (word_addr == A_C1) & ~pslverr_q;
	assign wr_den = access_done & pwrite_i & (word_addr == A_DEN) & ~pslverr_q;
	assign rd_set = access_done & ~pwrite_i & (word_addr == A_SET);

	always_comb begin
		mapped    = 1'b0;
		read_only = 1'b0;
		unique case (word_addr)
			A_S0, A_S1, A_DST, A_EP2, A_SET: begin
				mapped    = 1'b1;
				read_only = 1'b1;
			end
			A_C0, A_C1, A_DEN: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	assign dma_tc_valid = events_i.dma_tc & DMA_EPS;

	// status zero: sources set, clear register writes of zero clear
	always_comb begin
		set_zero = 8'h00;
		set_zero[S0_DMA_END]  = |dma_tc_valid; // RULE1
		// a pending unread set target suppresses the next set event
		set_zero[S0_SET_REQ]  = events_i.auto_set_done & ~set_target_pending_q; // RULE4 RULE5
		set_zero[S0_CLR_FEAT] = events_i.clear_feat_done; // RULE8
		set_zero[S0_STALL]    = events_i.ep_stall | events_i.set_feature_ep; // RULE7 RULE10
		keep_zero = wr_c0 ? pwdata_i[7:0] : 8'hFF;
		// reads and setup/standard requests never clear these
		status_zero_d = ((status_zero_q & keep_zero) | set_zero) & S0_IMPL_MASK; // RULE3 RULE6 RULE9 RULE11
	end

	// status one: set wins over all three clear sources (clear write, setup token, buffer write)
	always_comb begin
		set_one  = 8'h00;
		keep_one = wr_c1 ? pwdata_i[7:0] : 8'hFF; // RULE14
		set_one[S1_IN_NAK]  = events_i.ep0_in_nak; // RULE19
		set_one[S1_TX_DONE] = events_i.ep0_tx_ack; // RULE21
		set_one[S1_SUCCESS] = events_i.stage_success;
		set_one[S1_STG]     = events_i.stage_status;
		if (events_i.setup_token) begin
			keep_one[S1_SUCCESS] = 1'b0; // RULE15
			keep_one[S1_STG]     = 1'b0; // RULE15
		end
		if (events_i.ep0_wbuf_write && !wbuf_written_q) begin
			keep_one[S1_TX_DONE] = 1'b0; // RULE22
		end
		status_one_d = ((status_one_q & keep_one) | set_one) & S1_IMPL_MASK;
		status_one_d[S1_ZERO_BIT] = 1'b0; // RULE18
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			status_zero_q <= STATUS_ZERO_RST;
			status_one_q  <= STATUS_ONE_RST; // RULE18
		end else begin
			status_zero_q <= status_zero_d;
			status_one_q  <= status_one_d;
		end
	end

	// single interrupt: or of every source, so a new event in register
	// one, or any still-set source, keeps the line active
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (|status_zero_d) | (|status_one_d); // RULE13 RULE16 RULE17
		end
	end

	// unread set target register blocks later set interrupts
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			set_target_pending_q <= 1'b0;
		end else if (set_zero[S0_SET_REQ]) begin
			set_target_pending_q <= 1'b1; // RULE5
		end else if (rd_set) begin
			set_target_pending_q <= 1'b0; // RULE5
		end
	end

	// dma enables written by firmware; terminal count withdraws request
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			dma_enable_q <= DMA_ENABLE_RST;
		end else if (wr_den) begin
			dma_enable_q <= pwdata_i[8:0] & DMA_EPS;
		end else begin
			dma_enable_q <= dma_enable_q & ~dma_tc_valid; // RULE2
		end
	end

	// per-endpoint request and last-finished record
	genvar ep;
	generate
		for (ep = 0; ep < EP_CNT; ep++) begin : g_dma
			always_ff @(posedge clock_i or posedge rst_i) begin
				if (rst_i) begin
					dma_req_q[ep]  <= 1'b0;
					dma_done_q[ep] <= 1'b0;
				end else begin
					if (dma_tc_valid[ep]) begin
						dma_req_q[ep]  <= 1'b0; // RULE2
						dma_done_q[ep] <= 1'b1;
					end else begin
						dma_req_q[ep] <= dma_enable_q[ep] & DMA_EPS[ep]; // RULE2
						if (wr_den && pwdata_i[ep]) begin
							dma_done_q[ep] <= 1'b0;
						end
					end
				end
			end
		end
	endgenerate

	// ep0 halt masking window for endpoint status two bit 0
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ep0_mask_q <= 1'b0;
		end else if (events_i.ep0_mask_req) begin
			ep0_mask_q <= 1'b1; // RULE12
		end else if (events_i.setup_token) begin
			ep0_mask_q <= 1'b0; // RULE12
		end
	end

	// ep0 transmit: data leaves on the in token after nak control set
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			nak_armed_q <= 1'b0;
			tx_send_q   <= 1'b0;
		end else begin
			tx_send_q <= nak_armed_q & events_i.ep0_in_token; // RULE20
			if (events_i.ep0_nak_ctrl) begin
				nak_armed_q <= 1'b1; // RULE20
			end else if (events_i.ep0_in_token) begin
				nak_armed_q <= 1'b0;
			end
		end
	end

	// only the first buffer write after a completed send clears the flag
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wbuf_written_q <= 1'b0;
		end else if (events_i.ep0_tx_ack) begin
			wbuf_written_q <= 1'b0; // RULE22
		end else if (events_i.ep0_wbuf_write) begin
			wbuf_written_q <= 1'b1; // RULE22
		end
	end

	// apb slave: answer prepared in setup, ready in the access cycle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (setup_phase) begin
			pready_q  <= 1'b1;
			pslverr_q <= ~mapped | (pwrite_i & read_only); // RULE18
			prdata_q  <= 32'h0000_0000;
			if (!pwrite_i) begin
				unique case (word_addr)
					A_S0:    prdata_q[7:0] <= status_zero_q; // RULE3
					A_S1:    prdata_q[7:0] <= status_one_q; // RULE18
					A_DEN:   prdata_q[8:0] <= dma_enable_q;
					A_DST:   prdata_q[8:0] <= dma_done_q;
					A_EP2:   prdata_q[0]   <= events_i.ep0_halt & ~ep0_mask_q; // RULE12
					A_SET:   prdata_q[0]   <= set_target_pending_q;
					default: prdata_q      <= 32'h0000_0000;
				endcase
			end
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= pslverr_q & psel_i & penable_i & ~pready_q;
		end
	end

	assign prdata_o              = prdata_q;
	assign pready_o              = pready_q;
	assign pslverr_o             = pslverr_q;
	assign usb_irq_line_zero_o   = irq_q;
	assign controls_o            = {dma_req_q, tx_send_q};

endmodule // usb_irq_status

//--- rtl/usb_irq_pkg.sv
// package: register map, field positions, reset values and carriers
// for the usb function interrupt status block.
// assumes a 32-bit apb slave with 12 address bits.
package usb_irq_pkg;

	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;
	localparam int          EP_CNT        = 9;

	// printed offsets are not all word aligned: they are word indices
	localparam logic [31:0] IDX_STATUS_ZERO   = 32'hFFFFFE10;
	localparam logic [31:0] IDX_STATUS_ONE    = 32'hFFFFFE11;
	localparam logic [31:0] IDX_CLEAR_ZERO    = 32'hFFFFFE14;
	localparam logic [31:0] IDX_CLEAR_ONE     = 32'hFFFFFE15;
	localparam logic [31:0] IDX_DMA_ENABLE    = 32'hFFFFFE18;
	localparam logic [31:0] IDX_DMA_STATUS    = 32'hFFFFFE19;
	localparam logic [31:0] IDX_EP_STATUS_TWO = 32'hFFFFFE1A;
	localparam logic [31:0] IDX_SET_TARGET    = 32'hFFFFFE1B;

	// endpoints that own a dma channel: 1 to 4, 7, 8
	localparam logic [8:0]  DMA_EP_MASK   = 9'h19E;

	// status zero fields
	localparam int          S0_STALL      = 0;
	localparam int          S0_CLR_FEAT   = 1;
	localparam int          S0_SET_REQ    = 2;
	localparam int          S0_DMA_END    = 3;
	// status one fields
	localparam int          S1_STG        = 2;
	localparam int          S1_SUCCESS    = 3;
	localparam int          S1_TX_DONE    = 5;
	localparam int          S1_IN_NAK     = 6;
	localparam int          S1_ZERO_BIT   = 7;

	localparam logic [7:0]  STATUS_ZERO_RST = 8'h00;
	localparam logic [7:0]  STATUS_ONE_RST  = 8'h00;
	localparam logic [7:0]  S0_IMPL_MASK    = 8'h0F;
	localparam logic [7:0]  S1_IMPL_MASK    = 8'h6C;
	localparam logic [8:0]  DMA_ENABLE_RST  = 9'h000;

	// one-cycle event pulses and levels from the usb protocol engine
	typedef struct packed {
		logic [8:0] dma_tc;          // terminal count per endpoint
		logic       auto_set_done;   // status stage of auto set request done
		logic       set_feature_ep;  // set_feature endpoint received
		logic       clear_feat_done; // status stage of auto clear_feature done
		logic       ep_stall;        // any endpoint stalled
		logic       setup_token;     // setup token received
		logic       ep0_mask_req;    // ep0 set/clear_feature, get_status or fw request
		logic       ep0_halt;        // ep0 halt feature level
		logic       stage_status;    // control transfer entered status stage
		logic       stage_success;   // status stage completed
		logic       ep0_in_token;    // in token on ep0
		logic       ep0_in_nak;      // ep0 in token answered by nak
		logic       ep0_nak_ctrl;    // nak control bit written to one
		logic       ep0_tx_ack;      // host acknowledged ep0 data
		logic       ep0_wbuf_write;  // write access to ep0 write buffer
		logic       clr_target_read; // clear-request target register read
	} usb_events_t;

	typedef struct packed {
		logic [8:0] dma_req;
		logic       ep0_tx_send;
	} usb_controls_t;

endpackage

//--- verification/usb_irq_status_monitor.sv
// checker: flag, irq and control timing of the usb status block
// assumes it is bound to usb_irq_status and sees only its ports
`timescale 1ns/1ps
module usb_irq_status_monitor
	import usb_irq_pkg::*;
#(
	parameter logic [8:0] DMA_EPS = DMA_EP_MASK
) (
	input wire logic                        clock_i,
	input wire logic                        rst_i,
	input wire logic                        psel_i,
	input wire logic                        penable_i,
	input wire logic                        pwrite_i,
	input wire logic [usb_irq_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [usb_irq_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [3:0]                  pstrb_i,
	input wire logic [usb_irq_pkg::DATA_W-1:0] prdata_o,
	input wire logic                        pready_o,
	input wire logic                        pslverr_o,
	input wire usb_irq_pkg::usb_events_t    events_i,
	input wire usb_irq_pkg::usb_controls_t  controls_o,
	input wire logic                        usb_irq_line_zero_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic armed_q;
	logic mask_q;
	logic acc;
	assign acc = psel_i && penable_i && pready_o;
	// nak control armed, waiting for the next in token
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			armed_q <= 1'b0;
		else if (events_i.ep0_nak_ctrl)
			armed_q <= 1'b1;
		else if (events_i.ep0_in_token)
			armed_q <= 1'b0;
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			mask_q <= 1'b0;
		else if (events_i.ep0_mask_req)
			mask_q <= 1'b1;
		else if (events_i.setup_token)
			mask_q <= 1'b0;
	end
	dma_end_irq_a: assert property ((events_i.dma_tc & DMA_EPS) != 9'h0 |=>
		usb_irq_line_zero_o) else $error("no irq after dma end");
	dma_req_drop_a: assert property ((events_i.dma_tc & DMA_EPS) != 9'h0 |=>
		(controls_o.dma_req & $past(events_i.dma_tc)) == 9'h0) else $error("dma request kept");
	flag_irq_a: assert property (events_i.clear_feat_done || events_i.ep_stall ||
		events_i.ep0_in_nak || events_i.ep0_tx_ack |=> usb_irq_line_zero_o)
		else $error("no irq after flag event");
	stage_irq_a: assert property (events_i.stage_status && !events_i.setup_token |=>
		usb_irq_line_zero_o) else $error("no irq on status one change");
	tx_send_a: assert property (armed_q && events_i.ep0_in_token |=> controls_o.ep0_tx_send)
		else $error("ep0 data not sent");
	early_send_a: assert property (controls_o.ep0_tx_send |-> $past(armed_q) &&
		$past(events_i.ep0_in_token)) else $error("ep0 data sent early");
	irq_hold_a: assert property ($fell(usb_irq_line_zero_o) |-> $past(acc && pwrite_i) ||
		$past(events_i.setup_token) || $past(events_i.ep0_wbuf_write))
		else $error("irq dropped without clear");
	st1_read_a: assert property (acc && !pwrite_i && paddr_i == 12'h844 |->
		(prdata_o & ~{24'h0, S1_IMPL_MASK}) == 32'h0) else $error("status one spare bits set");
	st1_ro_a: assert property (acc && pwrite_i && paddr_i == 12'h844 |-> pslverr_o)
		else $error("status one write accepted");
	halt_mask_a: assert property (acc && !pwrite_i && paddr_i == 12'h868 && mask_q &&
		$past(mask_q) |-> !prdata_o[0]) else $error("halt bit not masked");
	cover property (acc && pwrite_i && paddr_i == 12'h854);
	cover property (controls_o.ep0_tx_send);
	cover property ($fell(usb_irq_line_zero_o));
endmodule // usb_irq_status_monitor

bind usb_irq_status usb_irq_status_monitor #(.DMA_EPS(DMA_EPS)) usb_irq_status_monitor_i (
	.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .events_i(events_i),
	.controls_o(controls_o), .usb_irq_line_zero_o(usb_irq_line_zero_o));

//--- verification/usb_host_model.sv
// partner model: usb protocol engine raising one-cycle event pulses
// assumes fire is called just after a rising clock edge
`timescale 1ns/1ps
module usb_host_model
	import usb_irq_pkg::*;
(
	input  wire logic  clock_i,
	output usb_events_t events_o
);
	usb_events_t ev_q = '0;
	logic        halt = 1'b0;
	always_comb begin
		events_o = ev_q;
		events_o.ep0_halt = halt;
	end
	// pulse for one cycle, then one idle cycle
	task automatic fire(input usb_events_t e);
		ev_q <= e;
		@(posedge clock_i);
		ev_q <= '0;
		@(posedge clock_i);
	endtask
endmodule // usb_host_model

//--- verification/usb_irq_status_tb_top.sv
// testbench: apb register access and usb event scenarios
// assumes the host model drives events and the monitor is bound
`timescale 1ns/1ps
module usb_irq_status_tb_top;
	import usb_irq_pkg::*;
	logic          clock_i;
	logic          rst_i;
	logic          psel, penable, pwrite, pready, pslverr, err, irq;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, rd;
	usb_events_t   ev;
	usb_controls_t ctl;
	int            err_count, n_tests, i;
	localparam logic [11:0] A_ST0 = 12'h840, A_ST1 = 12'h844, A_CLR0 = 12'h850;
	localparam logic [11:0] A_CLR1 = 12'h854, A_DEN = 12'h860, A_EP2 = 12'h868, A_SET = 12'h86C;
	usb_irq_status usb_irq_status_i (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.events_i(ev), .controls_o(ctl), .usb_irq_line_zero_o(irq));
	usb_host_model usb_host_model_i (.clock_i(clock_i), .events_o(ev));
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	function automatic logic [31:0] exp_dma(int ep);
		return DMA_EP_MASK[ep] ? 32'h8 : 32'h0;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic go(input usb_events_t e);
		usb_host_model_i.fire(e);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clock_i);
		$display("[ERR] %0t watchdog expired", $time);
		err_count++;
		wrap_up;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst_i = 1'b1;
		void'($urandom(32'hD828DF97));
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rdchk(A_ST0, {24'h0, STATUS_ZERO_RST});
		rdchk(A_ST1, {24'h0, STATUS_ONE_RST});
		apb(1'b1, A_ST1, $urandom);
		chk({31'h0, err}, 32'h1);
		for (i = 0; i < 3; i++) begin
			rdchk(12'hA00 | 12'($urandom & 32'h1FC), 32'h0);
			chk({31'h0, err}, 32'h1);
		end
		$display("test map finished");
		for (i = 0; i < 9; i++) begin
			apb(1'b1, A_DEN, 32'h1 << i);
			@(posedge clock_i);
			chk(32'(ctl.dma_req), 32'(DMA_EP_MASK & (9'h1 << i)));
			go('{dma_tc: 9'h1 << i, default: '0});
			rdchk(A_ST0, exp_dma(i));
			rdchk(A_ST0, exp_dma(i));
			chk(32'(ctl.dma_req), 32'h0);
			apb(1'b1, A_CLR0, $urandom & ~32'h8);
			rdchk(A_ST0, 32'h0);
		end
		$display("test dma finished");
		apb(1'b0, A_SET, 32'h0);
		go('{auto_set_done: 1'b1, default: '0});
		rdchk(A_ST0, 32'h4);
		apb(1'b0, A_SET, 32'h0);
		rdchk(A_ST0, 32'h4);
		go('{set_feature_ep: 1'b1, default: '0});
		rdchk(A_ST0, 32'h5);
		go('{clear_feat_done: 1'b1, default: '0});
		go('{clr_target_read: 1'b1, default: '0});
		rdchk(A_ST0, 32'h7);
		apb(1'b1, A_CLR0, ~32'h1);
		go('{ep_stall: 1'b1, default: '0});
		go('{setup_token: 1'b1, default: '0});
		rdchk(A_ST0, 32'h7);
		apb(1'b1, A_CLR0, 32'h0);
		chk({31'h0, irq}, 32'h0);
		go('{auto_set_done: 1'b1, default: '0});
		rdchk(A_ST0, 32'h4);
		apb(1'b1, A_CLR0, 32'h0);
		go('{auto_set_done: 1'b1, default: '0});
		rdchk(A_ST0, 32'h0);
		apb(1'b0, A_SET, 32'h0);
		chk(rd, 32'h1);
		chk({31'h0, irq}, 32'h0);
		$display("test requests finished");
		go('{stage_status: 1'b1, default: '0});
		chk({31'h0, irq}, 32'h1);
		go('{stage_success: 1'b1, default: '0});
		go('{ep0_in_nak: 1'b1, default: '0});
		rdchk(A_ST1, 32'h4C);
		go('{setup_token: 1'b1, default: '0});
		rdchk(A_ST1, 32'h40);
		go('{ep_stall: 1'b1, default: '0});
		apb(1'b1, A_CLR1, $urandom & ~32'h40);
		rdchk(A_ST1, 32'h0);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, A_CLR0, ~32'h1);
		rdchk(A_ST0, 32'h0);
		chk({31'h0, irq}, 32'h0);
		go('{ep0_nak_ctrl: 1'b1, default: '0});
		go('{ep0_in_token: 1'b1, default: '0});
		go('{ep0_tx_ack: 1'b1, default: '0});
		rdchk(A_ST1, 32'h20);
		go('{ep0_wbuf_write: 1'b1, default: '0});
		rdchk(A_ST1, 32'h0);
		$display("test status one finished");
		usb_host_model_i.halt <= 1'b1;
		rdchk(A_EP2, 32'h1);
		go('{ep0_mask_req: 1'b1, default: '0});
		rdchk(A_EP2, 32'h0);
		go('{setup_token: 1'b1, default: '0});
		rdchk(A_EP2, 32'h1);
		$display("test halt mask finished");
		wrap_up;
	end
endmodule // usb_irq_status_tb_top
